// ---- common/wdt_pkg.sv ----
// constants and types shared by the fail-safe watchdog and its prescaler
// assumes a single system clock with a synchronous active-high reset

package wdt_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int COUNT_W = 16;
   localparam int PRESC_W = 14;

   // ----------------------------------------
   // prescaler division factors
   // ----------------------------------------
   localparam logic [PRESC_W-1:0] DIV_SLOW_LAST = 14'h3FFF;   // divide by 16384
   localparam logic [PRESC_W-1:0] DIV_FAST_LAST = 14'h00FF;   // divide by 256
   localparam logic SEL_DIV_FAST = 1'b0;
   localparam logic SEL_DIV_SLOW = 1'b1;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   // 256 ticks of 256 cycles: 6.5536 ms at a 10 MHz system clock
   localparam logic [COUNT_W-1:0] RELOAD_RESET = 16'hFF00;
   localparam logic SEL_RESET = SEL_DIV_FAST;
   localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 16'hFFFF;

   // ----------------------------------------
   // interval range, at the reference clock rate
   // ----------------------------------------
   localparam real REF_CLOCK_MHZ = 80.0;
   localparam real MIN_INTERVAL_US = 3.2;
   localparam real MAX_INTERVAL_S = 13.42;
   localparam int MIN_INTERVAL_CYCLES = 256;           // one tick, reload all ones
   localparam longint MAX_INTERVAL_CYCLES = 64'd1073741824;  // 65536 ticks of 16384

   // ----------------------------------------
   // system clock of this build
   // ----------------------------------------
   localparam int SYS_CLOCK_HZ = 20000000;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_PREWARN,
      ST_RESET_REQ
   } wdt_state_t;

endpackage : wdt_pkg

// ---- core/fail_safe_watchdog_timer.sv ----
// fail-safe watchdog: 16-bit up counter, prewarning, then reset request
// assumes instruction strobes are one-cycle pulses from the cpu on sys_clk
//
// Contract
// - enabled and counting after every reset
// - off/on instructions stop and resume, anytime before the reset request
// - overflow gives prewarning, then reset request
// - 16-bit counter, tick is clock/16384 or /256
// - counter starts from programmed reload register
// - service in the run phase reloads counter and clears prescaler
// - intervals 3.2 us to 13.42 s at 80 MHz
// - reset defaults give 6.5 ms at 10 MHz

`timescale 1ns/1ps

module fail_safe_watchdog_timer
   import wdt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic watchdog_off_instruction,
   input wire logic watchdog_on_instruction,
   input wire logic service_instruction,
   input wire logic reload_write,
   input wire logic [COUNT_W-1:0] watchdog_reload_value,
   input wire logic div_sel_write,
   input wire logic div_sel,
   output logic prewarn_irq,
   output logic reset_request,
   output logic enabled,
   output logic [COUNT_W-1:0] count_value,
   output logic prewarn_active
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      wdt_state_t state;
      logic [COUNT_W-1:0] count;
      logic [COUNT_W-1:0] reload;
      logic div_sel;
      logic enabled;
      logic prewarn_irq;
      logic reset_request;
      logic prewarn_active;
   } wdt_t;

   wdt_t s_q;
   wdt_t s_d;
   logic tick;
   logic presc_clear;
   logic presc_run;
   logic overflow;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // a prescaler tick only counts while the prescaler is allowed to run;
   // a tick left over from before a disable is dropped, not deferred
   function automatic logic step_due(input logic tick_in, input logic run_in);
      step_due = tick_in && run_in;
   endfunction : step_due

   // the counter overflows on the step taken from all ones
   function automatic logic at_wrap(input logic [COUNT_W-1:0] value);
      at_wrap = (value == COUNT_ALL_ONES);
   endfunction : at_wrap

   // prewarn_active has a flop of its own so that every output is
   // registered; it follows the next state, so it rises with the pulse
   function automatic logic is_warn(input wdt_state_t st);
      is_warn = (st == ST_PREWARN);
   endfunction : is_warn

   // ----------------------------------------
   // timing
   // ----------------------------------------
   // with reload R and divider N the first overflow follows a service by
   // about (65536 - R) * N cycles plus one of pipeline: the prescaler tick
   // comes every N cycles, and the counter step follows it one cycle later
   // the prewarning phase runs one more full interval from R before the
   // reset request rises; a disable freezes both phases alike
   // limitation: a service in the same cycle as an overflow wins, so the
   // interval may stretch by one cycle at the very edge of expiry

   // ----------------------------------------
   // prescaler
   // ----------------------------------------
   // a service clears the prescaler so the full first tick is granted
   assign presc_clear = service_instruction && (s_q.state == ST_RUN);
   assign presc_run = s_q.enabled && (s_q.state != ST_RESET_REQ);

   wdt_prescaler u_prescaler (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .run(presc_run),
      .clear(presc_clear),
      .div_sel(s_q.div_sel),
      .tick(tick)
   );

   // ----------------------------------------
   // counter and sequence
   // ----------------------------------------
   // overflow is the tick that moves the counter past all ones
   assign overflow = step_due(tick, presc_run) && at_wrap(s_q.count);

   always_comb begin
      s_d = s_q;
      s_d.prewarn_irq = 1'b0;

      if (reload_write) begin
         s_d.reload = watchdog_reload_value;
      end
      if (div_sel_write) begin
         s_d.div_sel = div_sel;
      end

      // on wins if both strobes come together: the safe choice
      if (watchdog_on_instruction) begin
         s_d.enabled = 1'b1;
      end else if (watchdog_off_instruction) begin
         s_d.enabled = 1'b0;
      end

      case (s_q.state)
         ST_RUN: begin
            if (service_instruction) begin
               s_d.count = s_q.reload;
            end else if (overflow) begin
               // prewarning first; the reset follows one more interval later
               s_d.count = s_q.reload;
               s_d.prewarn_irq = 1'b1;
               s_d.state = ST_PREWARN;
            end else if (step_due(tick, presc_run)) begin
               s_d.count = s_q.count + 16'h0001;
            end
         end
         ST_PREWARN: begin
            // servicing is refused here: a failed system must not recover silently
            if (overflow) begin
               s_d.reset_request = 1'b1;
               s_d.state = ST_RESET_REQ;
            end else if (step_due(tick, presc_run)) begin
               s_d.count = s_q.count + 16'h0001;
            end
         end
         ST_RESET_REQ: begin
            // held until the system reset arrives
            s_d.reset_request = 1'b1;
         end
         default: begin
            s_d.state = ST_RUN;
         end
      endcase
      s_d.prewarn_active = is_warn(s_d.state);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q.state <= ST_RUN;
         s_q.count <= RELOAD_RESET;
         s_q.reload <= RELOAD_RESET;
         s_q.div_sel <= SEL_RESET;
         s_q.enabled <= 1'b1;
         s_q.prewarn_irq <= 1'b0;
         s_q.reset_request <= 1'b0;
         s_q.prewarn_active <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prewarn_irq = s_q.prewarn_irq;
   assign reset_request = s_q.reset_request;
   assign enabled = s_q.enabled;
   assign count_value = s_q.count;
   assign prewarn_active = s_q.prewarn_active;

endmodule : fail_safe_watchdog_timer

// ---- core/wdt_prescaler.sv ----
// watchdog prescaler: divides the system clock by 16384 or 256
// assumes run, clear and select come from logic on sys_clk

`timescale 1ns/1ps

module wdt_prescaler
   import wdt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic clear,
   input wire logic div_sel,
   output logic tick
);

   typedef struct packed {
      logic [PRESC_W-1:0] count;
      logic tick;
   } presc_t;

   presc_t s_q;
   presc_t s_d;
   logic [PRESC_W-1:0] last;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      last = (div_sel == SEL_DIV_SLOW) ? DIV_SLOW_LAST : DIV_FAST_LAST;
      if (clear) begin
         s_d.count = '0;
      end else if (run) begin
         if (s_q.count >= last) begin
            s_d.count = '0;
            s_d.tick = 1'b1;
         end else begin
            s_d.count = s_q.count + 14'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule : wdt_prescaler

// ---- tb/fail_safe_watchdog_timer_bench.sv ----
// self-checking bench for the fail-safe watchdog
// assumes 20 MHz sys_clk; strobes driven one cycle by nba
`timescale 1ns/1ps
module fail_safe_watchdog_timer_bench;
   import wdt_pkg::*;
   logic sys_clk = 0, sys_rst = 1, watchdog_off_instruction = 0, watchdog_on_instruction = 0;
   logic service_instruction = 0, reload_write = 0, div_sel_write = 0, div_sel = 0;
   logic [COUNT_W-1:0] watchdog_reload_value = 16'h0000, count_value, s;
   logic prewarn_irq, reset_request, enabled, prewarn_active;
   int num_errors = 0, total_checks = 0, n;
   fail_safe_watchdog_timer u_fail_safe_watchdog_timer (.*);
   initial forever #25 sys_clk = ~sys_clk;
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   // 0 off, 1 on, 2 service, 3 reload write, 4 divider write
   task automatic strobe(input int k);
      @(posedge sys_clk);
      {watchdog_off_instruction, watchdog_on_instruction} <= {k == 0, k == 1};
      {service_instruction, reload_write, div_sel_write} <= {k == 2, k == 3, k == 4};
      @(posedge sys_clk);
      {watchdog_off_instruction, watchdog_on_instruction} <= 2'b00;
      {service_instruction, reload_write, div_sel_write} <= 3'b000;
      @(posedge sys_clk);
   endtask : strobe
   // 0 count change, 1 prewarn pulse, 2 reset request; bounded
   task automatic wait_ev(input int k, input int lim);
      s = count_value;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (n > lim) begin
            num_errors++;
            report_and_stop();
         end
      end while (!((k == 0 && count_value !== s) || (k == 1 && prewarn_irq === 1'b1)
         || (k == 2 && reset_request === 1'b1)));
   endtask : wait_ev
   task automatic do_reset;
      sys_rst <= 1;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 0;
      @(posedge sys_clk);
      @(posedge sys_clk);
      chk("enabled", 1, enabled);
      chk("count", RELOAD_RESET, count_value);
   endtask : do_reset
   task automatic t_default_tick;
      wait_ev(0, 400);
      chk("first step", 16'hFF01, count_value);
      chk("fast tick", 1, n inside {[250:262]});
   endtask : t_default_tick
   task automatic t_slow_tick;
      div_sel <= SEL_DIV_SLOW;
      strobe(4);
      strobe(2);
      chk("serviced", RELOAD_RESET, count_value);
      wait_ev(0, 17000);
      chk("slow tick", 1, n inside {[16380:16392]});
      div_sel <= SEL_DIV_FAST;
      strobe(4);
   endtask : t_slow_tick
   task automatic t_off_on;
      strobe(0);
      chk("disabled", 0, enabled);
      s = count_value;
      repeat (600) @(posedge sys_clk);
      chk("frozen", s, count_value);
      strobe(1);
      chk("reenabled", 1, enabled);
      wait_ev(0, 400);
   endtask : t_off_on
   task automatic t_overflow;
      watchdog_reload_value <= 16'hFFFE;
      strobe(3);
      strobe(2);
      chk("reloaded", 16'hFFFE, count_value);
      wait_ev(1, 700);
      chk("interval", 1, n inside {[505:520]});
      chk("prewarn", 1, prewarn_active);
      @(posedge sys_clk);
      chk("irq pulse", 0, prewarn_irq);
      wait_ev(0, 400);
      strobe(2);
      chk("refused", 16'hFFFF, count_value);
      wait_ev(2, 700);
      chk("request", 1, reset_request);
      repeat (5) @(posedge sys_clk);
      chk("request held", 1, reset_request);
   endtask : t_overflow
   initial begin
      do_reset();
      t_default_tick();
      t_slow_tick();
      t_off_on();
      t_overflow();
      do_reset();
      chk("request cleared", 0, reset_request);
      report_and_stop();
   end
endmodule : fail_safe_watchdog_timer_bench

// ---- tb/wdt_checker.sv ----
// port checker for the fail-safe watchdog
// assumes one clock, sync active-high reset
`timescale 1ns/1ps
module wdt_checker
   import wdt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic watchdog_off_instruction,
   input wire logic watchdog_on_instruction,
   input wire logic service_instruction,
   input wire logic reload_write,
   input wire logic [COUNT_W-1:0] watchdog_reload_value,
   input wire logic prewarn_irq,
   input wire logic reset_request,
   input wire logic enabled,
   input wire logic [COUNT_W-1:0] count_value,
   input wire logic prewarn_active
);
   // shadow of the reload register, so a service has a known target
   logic [COUNT_W-1:0] reload_q;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) reload_q <= RELOAD_RESET;
      else if (reload_write) reload_q <= watchdog_reload_value;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_reset_state: assert property ($fell(sys_rst) |->
      enabled && count_value == RELOAD_RESET) else $error("reset state wrong");
   a_off_stops: assert property (watchdog_off_instruction && !watchdog_on_instruction
      |=> !enabled) else $error("off ignored");
   a_on_resumes: assert property (watchdog_on_instruction |=> enabled)
      else $error("on ignored");
   a_frozen_count: assert property (!enabled && !service_instruction
      |=> $stable(count_value)) else $error("count moved while off");
   a_service_load: assert property (service_instruction && !reload_write
      && !prewarn_active && !reset_request |=> count_value == reload_q)
      else $error("service did not reload");
   a_count_step: assert property (enabled && !service_instruction
      && count_value != COUNT_ALL_ONES |=> count_value == $past(count_value)
      || count_value == $past(count_value) + 16'h0001) else $error("bad count step");
   a_irq_on_wrap: assert property (prewarn_irq |->
      $past(count_value) == COUNT_ALL_ONES && prewarn_active) else $error("stray prewarn");
   a_req_after_warn: assert property ($rose(reset_request) |-> $past(prewarn_active))
      else $error("request without prewarn");
   a_req_held: assert property (reset_request |=> reset_request)
      else $error("request dropped");
endmodule : wdt_checker
bind fail_safe_watchdog_timer wdt_checker u_wdt_checker (.*);
